/* File: hw/srhr_pkg.sv */
// Package for the swapped-role hard reset sequencer.
// Assumes a 100 MHz clock; interval counts are reloadable defaults.
package srhr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CNT_W         = 24;

  // Default intervals in microseconds, overridable by config ports
  localparam int unsigned SWAP_RECOVERY_INTERVAL_US = 500;
  localparam int unsigned SAFE_ZERO_TIMEOUT_US      = 650;
  localparam int unsigned SOURCE_TURN_ON_TIME_US    = 275;

  localparam logic [CNT_W-1:0] SWAP_RECOVERY_CYCLES =
    CNT_W'(SWAP_RECOVERY_INTERVAL_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SAFE_ZERO_CYCLES =
    CNT_W'(SAFE_ZERO_TIMEOUT_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SOURCE_TURN_ON_CYCLES =
    CNT_W'(SOURCE_TURN_ON_TIME_US * 1000 / CLK_PERIOD_NS);

  typedef enum logic {
    SRHR_ROLE_SINK   = 1'b0,
    SRHR_ROLE_SOURCE = 1'b1
  } srhr_role_t;

  // Interval cycle counts
  typedef struct packed {
    logic [CNT_W-1:0] swap_recovery;
    logic [CNT_W-1:0] safe_zero;
    logic [CNT_W-1:0] source_turn_on;
  } srhr_cfg_t;

  // Power supply controls
  typedef struct packed {
    logic source_en;
    logic sink_en;
    logic current_limit;
  } srhr_supply_t;

endpackage

/* File: hw/srhr_seq.sv */
// Hard reset sequencer for a port whose power role is swapped.
// Assumes inputs synchronous to clk_in; supply reports vbus levels.
//
// Contract
// - Initiating new source signals reset, stops sourcing
// - Old source off, back to sink by timeout
// - Received reset: wait swap recovery, then source
// - No message: self-initiate, wait recovery, source (reset_tx_out is not pulsed for msg_timeout_in)
// - No safe five volt before bus safe zero
// - Reach safe five volt within turn-on time
// - Native source returns source, native sink returns sink
// - Returning sink limits load to default current
`timescale 1ns/10ps

module srhr_seq (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Port identity and configuration
  input  wire srhr_pkg::srhr_role_t  native_role_in,
  input  wire srhr_pkg::srhr_cfg_t   cfg_in,
  // Policy engine events
  input  wire logic                  swapped_in,
  input  wire logic                  start_reset_in,
  input  wire logic                  reset_rx_in,
  input  wire logic                  msg_timeout_in,
  // Bus voltage status
  input  wire logic                  vbus_safe_zero_in,
  input  wire logic                  vbus_safe_five_in,
  // Outputs
  output logic                       reset_tx_out,
  output srhr_pkg::srhr_supply_t     supply_out,
  output srhr_pkg::srhr_role_t       role_out,
  output logic                       busy_out,
  output logic                       timeout_err_out
);
  import srhr_pkg::*;

  typedef enum logic [2:0] {
    SRHR_IDLE,
    SRHR_SRC_OFF,
    SRHR_SWAP_WAIT,
    SRHR_ZERO_WAIT,
    SRHR_RAMP
  } srhr_state_t;

  srhr_state_t      state;
  logic [CNT_W-1:0] cnt;
  logic             cnt_done;
  logic             is_new_source;
  logic             is_new_sink;
  logic             take_src;
  logic             take_snk;
  logic             src_off_expired;
  logic             ramp_expired;

  // Opposite power role, shown while roles stay swapped
  function automatic srhr_role_t srhr_other_role(input srhr_role_t role);
    return (role == SRHR_ROLE_SINK) ? SRHR_ROLE_SOURCE : SRHR_ROLE_SINK;
  endfunction

  // Packs one set of supply controls
  function automatic srhr_supply_t srhr_supply(input logic src, input logic snk, input logic lim);
    srhr_supply_t s;
    s.source_en     = src;
    s.sink_en       = snk;
    s.current_limit = lim;
    return s;
  endfunction

  assign cnt_done        = (cnt == '0);
  assign is_new_source   = swapped_in && (native_role_in == SRHR_ROLE_SINK);
  assign is_new_sink     = swapped_in && (native_role_in == SRHR_ROLE_SOURCE);
  assign busy_out        = (state != SRHR_IDLE);
  // Events while busy are dropped, not queued
  assign take_src        = !busy_out && is_new_source && (start_reset_in || reset_rx_in);
  assign take_snk        = !busy_out && is_new_sink && (reset_rx_in || start_reset_in || msg_timeout_in);
  assign src_off_expired = (state == SRHR_SRC_OFF) && cnt_done && !vbus_safe_zero_in;
  assign ramp_expired    = (state == SRHR_RAMP) && cnt_done && !vbus_safe_five_in;

  // Sequence state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= SRHR_IDLE;
    end else begin
      unique case (state)
        SRHR_IDLE: begin
          if (take_src) begin
            state <= SRHR_SRC_OFF;
          end else if (take_snk) begin
            state <= SRHR_SWAP_WAIT;
          end
        end
        SRHR_SRC_OFF: begin
          // Sink operation reached once bus is safe or timeout expires
          if (vbus_safe_zero_in || cnt_done) begin
            state <= SRHR_IDLE;
          end
        end
        SRHR_SWAP_WAIT: begin
          if (cnt_done) begin
            state <= SRHR_ZERO_WAIT;
          end
        end
        SRHR_ZERO_WAIT: begin
          // No bound here: bus discharge is the far port's duty
          if (vbus_safe_zero_in) begin
            state <= SRHR_RAMP;
          end
        end
        SRHR_RAMP: begin
          if (vbus_safe_five_in || cnt_done) begin
            state <= SRHR_IDLE;
          end
        end
        default: begin
          state <= SRHR_IDLE;
        end
      endcase
    end
  end

  // Interval counter, loaded on entry to each timed step
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else begin
      unique case (state)
        SRHR_IDLE: begin
          if (take_src) begin
            cnt <= cfg_in.safe_zero;
          end else if (take_snk) begin
            cnt <= cfg_in.swap_recovery;
          end
        end
        SRHR_ZERO_WAIT: begin
          if (vbus_safe_zero_in) begin
            cnt <= cfg_in.source_turn_on;
          end
        end
        SRHR_SRC_OFF, SRHR_SWAP_WAIT, SRHR_RAMP: begin
          // Holds at zero so a late bus event cannot wrap it
          if (!cnt_done) begin
            cnt <= cnt - CNT_W'(1);
          end
        end
        default: begin
          cnt <= '0;
        end
      endcase
    end
  end

  // Reset signaling pulse, also sent when only attempted
  // Partner may never see it; the sequence goes on regardless
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_tx_out <= 1'b0;
    end else begin
      reset_tx_out <= (state == SRHR_IDLE) && start_reset_in && swapped_in;
    end
  end

  // Sticky error when turn-on or safe-zero window ran out
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timeout_err_out <= 1'b0;
    end else if (ramp_expired) begin
      timeout_err_out <= 1'b1;
    end else if (src_off_expired) begin
      timeout_err_out <= 1'b1;
    end else if (start_reset_in || reset_rx_in) begin
      timeout_err_out <= 1'b0;
    end
  end

  // Supply controls and role from flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_out <= '0;
      role_out   <= SRHR_ROLE_SINK;
    end else begin
      unique case (state)
        SRHR_IDLE: begin
          // Idle follows the swapped role only while the swap stands
          if (busy_out || !swapped_in) begin
            role_out <= native_role_in;
          end else begin
            role_out <= srhr_other_role(native_role_in);
          end
          supply_out.source_en     <= (role_out == SRHR_ROLE_SOURCE) && !(is_new_source && start_reset_in);
          supply_out.sink_en       <= (role_out == SRHR_ROLE_SINK);
          supply_out.current_limit <= 1'b0;
        end
        SRHR_SRC_OFF: begin
          role_out                 <= SRHR_ROLE_SINK;
          supply_out.source_en     <= 1'b0;
          supply_out.sink_en       <= 1'b1;
          supply_out.current_limit <= 1'b1;
        end
        SRHR_SWAP_WAIT, SRHR_ZERO_WAIT: begin
          role_out                 <= SRHR_ROLE_SOURCE;
          supply_out.source_en     <= 1'b0;
          supply_out.sink_en       <= 1'b0;
          supply_out.current_limit <= 1'b0;
        end
        SRHR_RAMP: begin
          role_out                 <= SRHR_ROLE_SOURCE;
          supply_out.source_en     <= 1'b1;
          supply_out.sink_en       <= 1'b0;
          supply_out.current_limit <= 1'b0;
        end
        default: begin
          supply_out <= srhr_supply(1'b0, 1'b0, 1'b0);
        end
      endcase
    end
  end

endmodule

/* File: tb/srhr_seq_assertions.sv */
// Port checker for the hard reset sequencer.
// Assumes all three cfg_in counts are 10.
`timescale 1ns/10ps
module srhr_seq_checker
  import srhr_pkg::*;
(
  // Clock, reset, inputs
  input wire logic         clk_in, rst_n_in, swapped_in, start_reset_in,
  input wire logic         reset_rx_in, msg_timeout_in, vbus_safe_zero_in, vbus_safe_five_in,
  input wire srhr_role_t   native_role_in,
  input wire srhr_cfg_t    cfg_in,
  // Outputs
  input wire logic         reset_tx_out, busy_out, timeout_err_out,
  input wire srhr_supply_t supply_out,
  input wire srhr_role_t   role_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence src_take;
    !busy_out && swapped_in && native_role_in == SRHR_ROLE_SINK && (start_reset_in || reset_rx_in);
  endsequence
  sequence snk_take;
    !busy_out && swapped_in && native_role_in == SRHR_ROLE_SOURCE && (reset_rx_in || msg_timeout_in);
  endsequence
  sequence at_sink;
    supply_out == 3'b011 && role_out == SRHR_ROLE_SINK;
  endsequence
  tx_pulse_a: assert property (!busy_out && swapped_in && start_reset_in |=> reset_tx_out)
    else $error("no reset signal");
  tx_cause_a: assert property (reset_tx_out |-> $past(start_reset_in) ##1 !reset_tx_out)
    else $error("stray reset signal");
  go_sink_a: assert property (src_take |-> ##2 at_sink)
    else $error("not back to sink");
  off_by_a: assert property (src_take |-> ##[2:16] !busy_out)
    else $error("sink return late");
  recov_a: assert property (snk_take |-> ##3 !supply_out.source_en [*8])
    else $error("sourcing too early");
  no_five_a: assert property ($rose(supply_out.source_en) |-> $past(vbus_safe_zero_in, 2))
    else $error("bus not at zero");
  turn_on_a: assert property ($rose(supply_out.source_en) |-> ##[1:13] !busy_out)
    else $error("turn-on too long");
  role_a: assert property ($fell(busy_out) |-> role_out == native_role_in)
    else $error("wrong role");
endmodule
bind srhr_seq srhr_seq_checker srhr_seq_checker_i (.*);

/* File: tb/srhr_bus_model.sv */
// Far port and bus voltage model.
// Bus is at zero only when neither side sources.
`timescale 1ns/10ps
module srhr_bus_model (
  input  wire logic clk_in, src_in, far_in, stall_in,
  output logic      zero_out, five_out
);
  logic [3:0] cnt;
  // Ramp takes a few cycles; stall never reaches five
  always_ff @(posedge clk_in) cnt <= src_in ? cnt + 4'(cnt != 4'hf) : 4'h0;
  assign zero_out = !src_in && !far_in;
  assign five_out = src_in && !stall_in && cnt > 4'h2;
endmodule

/* File: tb/srhr_seq_tb_top.sv */
// Testbench for the hard reset sequencer.
// Assumes counts of 10 cycles and the bus model.
`timescale 1ns/10ps
module srhr_seq_tb_top;
  import srhr_pkg::*;
  logic clk_in = 0, rst_n_in = 0, swapped_in = 0, start_reset_in = 0, reset_rx_in = 0;
  logic msg_timeout_in = 0, far = 0, stall = 0, vbus_safe_zero_in, vbus_safe_five_in;
  logic reset_tx_out, busy_out, timeout_err_out;
  srhr_role_t native_role_in = SRHR_ROLE_SINK, role_out;
  srhr_cfg_t cfg_in = {24'h00000a, 24'h00000a, 24'h00000a};
  srhr_supply_t supply_out;
  int error_cnt = 0, checks_done = 0;
  always #5 clk_in = ~clk_in;
  srhr_seq srhr_seq_i (.*);
  srhr_bus_model srhr_bus_model_i (.clk_in, .src_in(supply_out.source_en), .far_in(far),
    .stall_in(stall), .zero_out(vbus_safe_zero_in), .five_out(vbus_safe_five_in));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One event with roles swapped; e: 0 start, 1 received, 2 no message
  task automatic fire(srhr_role_t r, int e, logic f);
    @(posedge clk_in) native_role_in <= r;
    swapped_in <= 1;
    repeat (2) @(posedge clk_in);
    @(posedge clk_in) far <= f;
    {msg_timeout_in, reset_rx_in, start_reset_in} <= 3'(1 << e);
    @(posedge clk_in) swapped_in <= 0;
    {msg_timeout_in, reset_rx_in, start_reset_in} <= 3'h0;
    #1;
  endtask
  task automatic t_src(int e, logic f);
    int n = 0;
    fire(SRHR_ROLE_SINK, e, f);
    chk(reset_tx_out, e == 0);
    @(posedge clk_in) #1;
    chk(supply_out, 3'h3);
    chk(role_out, SRHR_ROLE_SINK);
    while (busy_out !== 0 && n < 40) @(posedge clk_in) #1 n++;
    chk(n <= 11, 1);
    chk(timeout_err_out, f);
    $display("t_src done");
  endtask
  task automatic t_snk(int e, int d, logic s);
    int n = 0;
    stall <= s;
    fire(SRHR_ROLE_SOURCE, e, 1);
    while (supply_out.source_en !== 1 && n < 60) @(posedge clk_in) begin
      if (n == d) far <= 0;
      #1 n++;
    end
    chk(n > d && n >= 10, 1);
    chk(role_out, SRHR_ROLE_SOURCE);
    n = 0;
    while (busy_out !== 0 && n < 40) @(posedge clk_in) #1 n++;
    chk(n <= 11 && timeout_err_out === s, 1);
    $display("t_snk done");
  endtask
  task automatic t_rst;
    fire(SRHR_ROLE_SOURCE, 1, 1);
    @(posedge clk_in) rst_n_in <= 0;
    #1;
    chk({busy_out, reset_tx_out, timeout_err_out, supply_out, role_out}, 8'h00);
    @(posedge clk_in) rst_n_in <= 1;
    far <= 0;
    @(posedge clk_in) #1;
    chk(busy_out, 0);
    $display("t_rst done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000 error_cnt++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    t_src(0, 0);
    t_src(1, 0);
    t_src(0, 1);
    t_snk(1, 15, 0);
    t_snk(2, 1, 0);
    t_snk(1, 2, 1);
    t_rst;
    final_report;
  end
endmodule
